// *** inc/ssrx_defs.svh ***
// constants for the synchronous serial receiver
// Overview of operation
// (RULE1) master receive turns off the data pin driver.
// (RULE2) reception starts when single or continuous receive enable is set.
// (RULE3) single receive: master clocks one character, then clears single enable.
// (RULE4) continuous receive: master clocks without pause until the bit is cleared.
// (RULE5) clearing continuous mid-character stops the clock and drops the partial character.
// (RULE6) both set: single clears after the first character, continuous governs.
// (RULE7) data is sampled on the trailing clock edge into the shift register.
// (RULE8) complete character sets the receive flag and enters a two-entry queue.
// (RULE9) data register shows low eight bits of the oldest character.
// (RULE10) receive flag stays high while the queue is not empty.
// (RULE11) slave takes the clock from the clock pin and leaves it undriven.
// (RULE12) data changes on leading edge, valid on trailing, one bit per cycle.
// (RULE13) an external master supplies exactly one clock per data bit.
// (RULE14) a third character with a full queue sets overrun, queue kept.
// (RULE15) during overrun queued data stays readable and nothing new is taken.
// (RULE16) overrun in single mode is cleared by reading the data register.
// (RULE17) overrun in continuous mode clears by dropping continuous or port enable.
// (RULE18) nine-bit mode shifts nine bits; ninth bit of oldest shows in status.
// (RULE19) software reads the ninth bit before the low eight bits.
// (RULE20) software sets mode bits with both receive enables clear before starting.
// (RULE21) receive interrupt when a character is queued and enabled.
// (RULE22) software programs divisor and speed selects before receiving.
// (RULE23) each data register read pops the oldest character.
`ifndef SSRX_DEFS_SVH
`define SSRX_DEFS_SVH
`define SSRX_ADDR_CTRL    4'h0
`define SSRX_ADDR_DATA    4'h1
`define SSRX_ADDR_DIVLO   4'h2
`define SSRX_ADDR_DIVHI   4'h3
`define SSRX_ADDR_STAT    4'h4
`define SSRX_B_SERIAL_PORT_ENABLE       7
`define SSRX_B_RX9        6
`define SSRX_B_SINGLE_RECEIVE_ENABLE       5
`define SSRX_B_CONTINUOUS_RECEIVE_ENABLE       4
`define SSRX_B_CLOCK_SOURCE_MASTER       3
`define SSRX_B_RECEIVE_INTERRUPT_ENABLE       2
`define SSRX_B_HIGH_SPEED_BAUD_SELECT       1
`define SSRX_B_WIDE_DIVISOR_SELECT      0
`define SSRX_S_OVERRUN_ERROR_FLAG       1
`define SSRX_S_RECEIVED_NINTH_BIT       0
`define SSRX_S_RECEIVE_FLAG       2
`define SSRX_BITS8        4'h8
`define SSRX_BITS9        4'h9
`define SSRX_DEPTH        2'h2
`endif

// *** inc/ssrx_pkg.sv ***
// types for the synchronous serial receiver
package ssrx_pkg;
  typedef enum logic [2:0] {
    SSRX_IDLE = 3'b001,
    SSRX_LOW  = 3'b010,
    SSRX_HIGH = 3'b100
  } ssrx_phase_type;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } ssrx_bus_type;

  typedef struct packed {
    ssrx_phase_type phase;
    logic [7:0]     ctrl;
    logic [7:0]     div_lo;
    logic [7:0]     div_hi;
    logic [15:0]    div_cnt;
    logic [8:0]     shreg;
    logic [3:0]     bitcnt;
    logic [8:0]     q0;
    logic [8:0]     q1;
    logic [1:0]     qcnt;
    logic           overrun_error_flag;
    logic           ovr_single;
    logic [7:0]     rdata;
    logic           ck_out;
    logic [1:0]     ck_sync;
    logic [1:0]     dt_sync;
    logic           ck_prev;
  } ssrx_state_type;
endpackage

// *** design/ssrx_top.sv ***
// synchronous serial receiver core
`timescale 1ns/1ps
`include "ssrx_defs.svh"
module ssrx_top (
  // clock and reset
  input  wire logic                sys_clk,
  input  wire logic                srst,
  // register port
  input  wire ssrx_pkg::ssrx_bus_type bus,
  output logic [7:0]               rdata,
  // link pins
  input  wire logic                ck_pin_in,
  output logic                     ck_pin_out,
  output logic                     ck_pin_oe,
  input  wire logic                dt_pin_in,
  output logic                     dt_pin_out,
  output logic                     dt_pin_oe,
  // events
  output logic                     receive_flag,
  output logic                     receive_irq
);
  ssrx_pkg::ssrx_state_type s_r;
  ssrx_pkg::ssrx_state_type s_nxt;

  logic       serial_port_enable;
  logic       single_receive_enable;
  logic       continuous_receive_enable;
  logic       clock_source_master;
  logic       ninth_bit_receive_select;
  logic       active;
  logic [3:0] nbits;
  logic [15:0] div_load;
  logic       ck_sync;
  logic       trail_edge;
  logic       rd_data;
  logic       done;

  assign serial_port_enable                      = s_r.ctrl[`SSRX_B_SERIAL_PORT_ENABLE];
  assign single_receive_enable     = s_r.ctrl[`SSRX_B_SINGLE_RECEIVE_ENABLE];
  assign continuous_receive_enable = s_r.ctrl[`SSRX_B_CONTINUOUS_RECEIVE_ENABLE];
  assign clock_source_master       = s_r.ctrl[`SSRX_B_CLOCK_SOURCE_MASTER];
  assign ninth_bit_receive_select  = s_r.ctrl[`SSRX_B_RX9];
  assign active = serial_port_enable && (single_receive_enable || continuous_receive_enable) && !s_r.overrun_error_flag; // RULE2 RULE15
  assign nbits  = ninth_bit_receive_select ? `SSRX_BITS9 : `SSRX_BITS8; // RULE18
  assign ck_sync = s_r.ck_sync[1];
  assign rd_data = bus.rd && (bus.addr == `SSRX_ADDR_DATA);

  // divisor: wide select uses high byte, high speed halves the half-period
  always_comb begin
    div_load = s_r.ctrl[`SSRX_B_WIDE_DIVISOR_SELECT] ? {s_r.div_hi, s_r.div_lo} : {8'h00, s_r.div_lo};
    if (!s_r.ctrl[`SSRX_B_HIGH_SPEED_BAUD_SELECT]) begin
      div_load = {div_load[14:0], 1'b1};
    end
  end

  // trailing edge: master uses own falling clock, slave the synced pin
  assign trail_edge = clock_source_master
                    ? (s_r.phase == ssrx_pkg::SSRX_HIGH && s_r.div_cnt == 16'h0000)
                    : (s_r.ck_prev && !ck_sync); // RULE11 RULE7 RULE12

  always_comb begin
    s_nxt = s_r;
    done  = 1'b0;
    s_nxt.ck_sync = {s_r.ck_sync[0], ck_pin_in};
    s_nxt.dt_sync = {s_r.dt_sync[0], dt_pin_in};
    s_nxt.ck_prev = ck_sync;
    s_nxt.rdata   = s_r.q0[7:0]; // RULE9
    // register writes
    if (bus.wr) begin
      case (bus.addr)
        `SSRX_ADDR_CTRL:  s_nxt.ctrl   = bus.wdata;
        `SSRX_ADDR_DIVLO: s_nxt.div_lo = bus.wdata;
        `SSRX_ADDR_DIVHI: s_nxt.div_hi = bus.wdata;
        default:          s_nxt.ctrl   = s_nxt.ctrl;
      endcase
    end
    // read data
    case (bus.addr)
      `SSRX_ADDR_CTRL:  s_nxt.rdata = s_r.ctrl;
      `SSRX_ADDR_DATA:  s_nxt.rdata = s_r.q0[7:0]; // RULE9
      `SSRX_ADDR_DIVLO: s_nxt.rdata = s_r.div_lo;
      `SSRX_ADDR_DIVHI: s_nxt.rdata = s_r.div_hi;
      `SSRX_ADDR_STAT:  begin
        s_nxt.rdata = 8'h00;
        s_nxt.rdata[`SSRX_S_RECEIVED_NINTH_BIT] = s_r.q0[8]; // RULE18
        s_nxt.rdata[`SSRX_S_OVERRUN_ERROR_FLAG] = s_r.overrun_error_flag;
        s_nxt.rdata[`SSRX_S_RECEIVE_FLAG] = (s_r.qcnt != 2'h0);
      end
      default: s_nxt.rdata = 8'h00;
    endcase
    // pop on data read
    if (rd_data && s_r.qcnt != 2'h0) begin
      s_nxt.q0   = s_r.q1; // RULE23
      s_nxt.qcnt = s_r.qcnt - 2'h1;
    end
    if (rd_data && s_r.overrun_error_flag && s_r.ovr_single) begin
      s_nxt.overrun_error_flag = 1'b0; // RULE16
    end
    // shift engine
    case (s_r.phase)
      ssrx_pkg::SSRX_IDLE: begin
        s_nxt.ck_out = 1'b0;
        s_nxt.bitcnt = 4'h0;
        if (active) begin
          s_nxt.phase   = ssrx_pkg::SSRX_LOW;
          s_nxt.div_cnt = div_load;
        end
      end
      ssrx_pkg::SSRX_LOW: begin
        if (clock_source_master) begin
          s_nxt.div_cnt = s_r.div_cnt - 16'h0001;
          if (s_r.div_cnt == 16'h0000) begin
            s_nxt.phase   = ssrx_pkg::SSRX_HIGH; // leading edge RULE12
            s_nxt.ck_out  = 1'b1;
            s_nxt.div_cnt = div_load;
          end
        end else begin
          s_nxt.phase = ssrx_pkg::SSRX_HIGH;
        end
      end
      ssrx_pkg::SSRX_HIGH: begin
        if (clock_source_master) begin
          s_nxt.div_cnt = s_r.div_cnt - 16'h0001;
        end
        if (trail_edge) begin
          s_nxt.ck_out = 1'b0;
          s_nxt.shreg  = {s_r.dt_sync[1], s_r.shreg[8:1]}; // RULE7
          s_nxt.bitcnt = s_r.bitcnt + 4'h1;
          s_nxt.div_cnt = div_load;
          if (clock_source_master) begin
            s_nxt.phase = ssrx_pkg::SSRX_LOW;
          end
          if (s_r.bitcnt + 4'h1 == nbits) begin
            done = 1'b1;
            s_nxt.bitcnt = 4'h0;
            s_nxt.phase  = ssrx_pkg::SSRX_LOW;
          end
        end
      end
      default: s_nxt.phase = ssrx_pkg::SSRX_IDLE;
    endcase
    if (done) begin
      if (s_nxt.qcnt == `SSRX_DEPTH) begin
        s_nxt.overrun_error_flag       = 1'b1; // RULE14
        s_nxt.ovr_single = !continuous_receive_enable;
      end else if (s_nxt.qcnt == 2'h1) begin
        s_nxt.q1   = ninth_bit_receive_select ? {s_r.dt_sync[1], s_r.shreg[8:1]}
                                              : {1'b0, s_r.dt_sync[1], s_r.shreg[8:2]};
        s_nxt.qcnt = 2'h2; // RULE8
      end else begin
        s_nxt.q0   = ninth_bit_receive_select ? {s_r.dt_sync[1], s_r.shreg[8:1]}
                                              : {1'b0, s_r.dt_sync[1], s_r.shreg[8:2]};
        s_nxt.qcnt = 2'h1; // RULE8
      end
      s_nxt.ctrl[`SSRX_B_SINGLE_RECEIVE_ENABLE] = 1'b0; // RULE3 RULE6
      if (!continuous_receive_enable) begin
        s_nxt.phase = ssrx_pkg::SSRX_IDLE; // RULE3
      end
    end
    // continuous dropped: stop clock, discard partial
    if (!s_nxt.ctrl[`SSRX_B_CONTINUOUS_RECEIVE_ENABLE] && continuous_receive_enable) begin
      s_nxt.phase  = ssrx_pkg::SSRX_IDLE; // RULE5
      s_nxt.ck_out = 1'b0;
      s_nxt.bitcnt = 4'h0;
      if (!s_r.ovr_single) begin
        s_nxt.overrun_error_flag = 1'b0; // RULE17
      end
    end
    if (s_r.phase != ssrx_pkg::SSRX_IDLE && !active && !done) begin
      s_nxt.phase  = ssrx_pkg::SSRX_IDLE; // RULE4 RULE5
      s_nxt.ck_out = 1'b0;
      s_nxt.bitcnt = 4'h0;
    end
    // port disabled: reset the unit
    if (!s_nxt.ctrl[`SSRX_B_SERIAL_PORT_ENABLE]) begin
      s_nxt.phase      = ssrx_pkg::SSRX_IDLE; // RULE17
      s_nxt.qcnt       = 2'h0;
      s_nxt.overrun_error_flag       = 1'b0;
      s_nxt.ovr_single = 1'b0;
      s_nxt.bitcnt     = 4'h0;
      s_nxt.ck_out     = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s_r       <= '0;
      s_r.phase <= ssrx_pkg::SSRX_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rdata        = s_r.rdata;
  assign dt_pin_out   = 1'b0;
  assign dt_pin_oe    = 1'b0; // RULE1
  assign ck_pin_out   = s_r.ck_out;
  assign ck_pin_oe    = serial_port_enable && clock_source_master; // RULE11
  assign receive_flag = (s_r.qcnt != 2'h0); // RULE10
  assign receive_irq  = receive_flag && s_r.ctrl[`SSRX_B_RECEIVE_INTERRUPT_ENABLE]; // RULE21

  a_flag_tracks_queue: assert property (@(posedge sys_clk) disable iff (srst) // RULE10
    (s_r.qcnt == 2'h0) |-> !receive_flag)
    else $error("receive flag set with empty queue");
  a_data_pin_off: assert property (@(posedge sys_clk) disable iff (srst) // RULE1
    !dt_pin_oe)
    else $error("data pin driven");
  a_slave_clk_off: assert property (@(posedge sys_clk) disable iff (srst) // RULE11
    !clock_source_master |-> !ck_pin_oe)
    else $error("slave drives clock pin");
  a_queue_max_two: assert property (@(posedge sys_clk) disable iff (srst) // RULE8
    s_r.qcnt <= `SSRX_DEPTH)
    else $error("queue above two");
  a_ovr_keeps_q: assert property (@(posedge sys_clk) disable iff (srst) // RULE14
    (s_r.overrun_error_flag && !rd_data && serial_port_enable) |=> $stable(s_r.q0) && $stable(s_r.q1))
    else $error("queue changed during overrun");
  a_ovr_no_clock: assert property (@(posedge sys_clk) disable iff (srst) // RULE15
    s_r.overrun_error_flag |=> s_r.phase == ssrx_pkg::SSRX_IDLE)
    else $error("shifting during overrun");
  a_single_clears: assert property (@(posedge sys_clk) disable iff (srst) // RULE3
    (done && !bus.wr) |=> !single_receive_enable)
    else $error("single enable not cleared");
  a_pop_on_read: assert property (@(posedge sys_clk) disable iff (srst) // RULE23
    (rd_data && s_r.qcnt == 2'h2 && !done && serial_port_enable && !bus.wr) |=> s_r.qcnt == 2'h1)
    else $error("read did not pop");
  a_irq_gate: assert property (@(posedge sys_clk) disable iff (srst) // RULE21
    receive_irq |-> receive_flag && s_r.ctrl[`SSRX_B_RECEIVE_INTERRUPT_ENABLE])
    else $error("irq without cause");
  a_continuous_receive_enable_drop_stops: assert property (@(posedge sys_clk) disable iff (srst) // RULE5
    ($fell(continuous_receive_enable) && !single_receive_enable) |-> s_r.phase == ssrx_pkg::SSRX_IDLE)
    else $error("clock kept after continuous drop");

  // pin drivers, start and stop
  a_data_out_low: assert property (@(posedge sys_clk) disable iff (srst) // RULE1
    !dt_pin_out)
    else $error("data pin output not low");
  a_master_clk_oe: assert property (@(posedge sys_clk) disable iff (srst) // RULE11
    (serial_port_enable && clock_source_master) |-> ck_pin_oe)
    else $error("master does not drive clock pin");
  a_idle_waits: assert property (@(posedge sys_clk) disable iff (srst) // RULE2
    (s_r.phase == ssrx_pkg::SSRX_IDLE && !active) |=> s_r.phase == ssrx_pkg::SSRX_IDLE)
    else $error("left idle without enable");
  a_enable_starts: assert property (@(posedge sys_clk) disable iff (srst) // RULE2
    (s_r.phase == ssrx_pkg::SSRX_IDLE && active && !bus.wr) |=> s_r.phase == ssrx_pkg::SSRX_LOW)
    else $error("enable did not start reception");
  a_start_loads_div: assert property (@(posedge sys_clk) disable iff (srst) // RULE2
    (s_r.phase == ssrx_pkg::SSRX_IDLE && active && !bus.wr) |=> s_r.div_cnt == $past(div_load))
    else $error("divisor not loaded at start");
  a_idle_clk_low: assert property (@(posedge sys_clk) disable iff (srst) // RULE5
    s_r.phase == ssrx_pkg::SSRX_IDLE |-> !ck_pin_out)
    else $error("clock high while idle");
  a_idle_no_bits: assert property (@(posedge sys_clk) disable iff (srst) // RULE5
    s_r.phase == ssrx_pkg::SSRX_IDLE |-> s_r.bitcnt == 4'h0)
    else $error("partial bits kept while idle");
  a_single_stops: assert property (@(posedge sys_clk) disable iff (srst) // RULE3
    (done && !continuous_receive_enable && !bus.wr) |=> s_r.phase == ssrx_pkg::SSRX_IDLE)
    else $error("single receive did not stop");
  a_cont_goes_on: assert property (@(posedge sys_clk) disable iff (srst) // RULE4
    (done && continuous_receive_enable && !bus.wr) |=> s_r.phase == ssrx_pkg::SSRX_LOW)
    else $error("continuous receive paused");
  a_both_single_clr: assert property (@(posedge sys_clk) disable iff (srst) // RULE6
    (done && single_receive_enable && continuous_receive_enable && !bus.wr) |=> !single_receive_enable && continuous_receive_enable)
    else $error("single not cleared with both set");
  a_continuous_receive_enable_drop_idle: assert property (@(posedge sys_clk) disable iff (srst) // RULE5
    (bus.wr && bus.addr == `SSRX_ADDR_CTRL && !bus.wdata[`SSRX_B_CONTINUOUS_RECEIVE_ENABLE] && continuous_receive_enable) |=> s_r.bitcnt == 4'h0)
    else $error("partial character kept");
  a_continuous_receive_enable_drop_clk: assert property (@(posedge sys_clk) disable iff (srst) // RULE5
    (bus.wr && bus.addr == `SSRX_ADDR_CTRL && !bus.wdata[`SSRX_B_CONTINUOUS_RECEIVE_ENABLE] && continuous_receive_enable) |=> !ck_pin_out)
    else $error("clock kept after continuous clear");
  // shift clock and sampling
  a_low_clk_low: assert property (@(posedge sys_clk) disable iff (srst) // RULE12
    s_r.phase == ssrx_pkg::SSRX_LOW |-> !ck_pin_out)
    else $error("clock high in low phase");
  a_master_rise: assert property (@(posedge sys_clk) disable iff (srst) // RULE12
    (clock_source_master && s_r.phase == ssrx_pkg::SSRX_LOW && s_r.div_cnt == 16'h0000 && active && !bus.wr) |=> ck_pin_out)
    else $error("leading edge missing");
  a_master_fall: assert property (@(posedge sys_clk) disable iff (srst) // RULE7
    (clock_source_master && s_r.phase == ssrx_pkg::SSRX_HIGH && s_r.div_cnt == 16'h0000) |=> !ck_pin_out)
    else $error("trailing edge missing");
  a_high_steady: assert property (@(posedge sys_clk) disable iff (srst) // RULE12
    (clock_source_master && s_r.phase == ssrx_pkg::SSRX_HIGH && s_r.div_cnt != 16'h0000 && active && !bus.wr) |=> $stable(ck_pin_out))
    else $error("clock changed mid half period");
  a_master_count: assert property (@(posedge sys_clk) disable iff (srst) // RULE12
    (clock_source_master && s_r.phase == ssrx_pkg::SSRX_LOW && s_r.div_cnt != 16'h0000) |=> s_r.div_cnt == $past(s_r.div_cnt) - 16'h0001)
    else $error("divisor count skipped");
  a_shift_on_trail: assert property (@(posedge sys_clk) disable iff (srst) // RULE7
    (s_r.phase == ssrx_pkg::SSRX_HIGH && trail_edge) |=> s_r.shreg == {$past(s_r.dt_sync[1]), $past(s_r.shreg[8:1])})
    else $error("bit not shifted on trailing edge");
  a_no_shift_low: assert property (@(posedge sys_clk) disable iff (srst) // RULE7
    s_r.phase != ssrx_pkg::SSRX_HIGH |=> $stable(s_r.shreg))
    else $error("shift outside high phase");
  a_slave_high: assert property (@(posedge sys_clk) disable iff (srst) // RULE11
    (!clock_source_master && s_r.phase == ssrx_pkg::SSRX_LOW && active && !bus.wr) |=> s_r.phase == ssrx_pkg::SSRX_HIGH)
    else $error("slave not armed for edges");
  a_slave_trail: assert property (@(posedge sys_clk) disable iff (srst) // RULE11
    (!clock_source_master && s_r.phase == ssrx_pkg::SSRX_HIGH && s_r.ck_prev && !ck_sync && active && !bus.wr) |=> s_r.bitcnt != $past(s_r.bitcnt))
    else $error("slave edge not counted");
  // characters and overrun
  a_first_queued: assert property (@(posedge sys_clk) disable iff (srst) // RULE8
    (done && s_r.qcnt == 2'h0 && !bus.wr) |=> receive_flag)
    else $error("flag not set on character");
  a_second_queued: assert property (@(posedge sys_clk) disable iff (srst) // RULE8
    (done && s_r.qcnt == 2'h1 && !rd_data && !bus.wr) |=> s_r.qcnt == 2'h2)
    else $error("second character not queued");
  a_first_data: assert property (@(posedge sys_clk) disable iff (srst) // RULE18
    (done && s_r.qcnt == 2'h0 && ninth_bit_receive_select && !bus.wr) |=> s_r.q0 == {$past(s_r.dt_sync[1]), $past(s_r.shreg[8:1])})
    else $error("nine bit character wrong");
  a_eight_bit_top: assert property (@(posedge sys_clk) disable iff (srst) // RULE18
    (done && s_r.qcnt == 2'h0 && !ninth_bit_receive_select && !bus.wr) |=> !s_r.q0[8])
    else $error("ninth bit set in eight bit mode");
  a_done_count: assert property (@(posedge sys_clk) disable iff (srst) // RULE18
    done |-> s_r.bitcnt == nbits - 4'h1)
    else $error("character length wrong");
  a_ovr_sets: assert property (@(posedge sys_clk) disable iff (srst) // RULE14
    (done && s_r.qcnt == 2'h2 && !rd_data && !bus.wr) |=> s_r.overrun_error_flag && s_r.qcnt == 2'h2)
    else $error("overrun not flagged");
  a_ovr_idle_stays: assert property (@(posedge sys_clk) disable iff (srst) // RULE15
    (s_r.overrun_error_flag && s_r.phase == ssrx_pkg::SSRX_IDLE) |=> s_r.phase == ssrx_pkg::SSRX_IDLE)
    else $error("reception restarted in overrun");
  a_ovr_readable: assert property (@(posedge sys_clk) disable iff (srst) // RULE15
    (s_r.overrun_error_flag && rd_data) |=> rdata == $past(s_r.q0[7:0]))
    else $error("queue unreadable in overrun");
  a_single_ovr_clr: assert property (@(posedge sys_clk) disable iff (srst) // RULE16
    (s_r.overrun_error_flag && s_r.ovr_single && rd_data) |=> !s_r.overrun_error_flag)
    else $error("single overrun not cleared by read");
  a_cont_ovr_held: assert property (@(posedge sys_clk) disable iff (srst) // RULE17
    (s_r.overrun_error_flag && !s_r.ovr_single && !bus.wr) |=> s_r.overrun_error_flag)
    else $error("continuous overrun lost");
  a_cont_ovr_clr: assert property (@(posedge sys_clk) disable iff (srst) // RULE17
    (s_r.overrun_error_flag && !s_r.ovr_single && bus.wr && bus.addr == `SSRX_ADDR_CTRL && !bus.wdata[`SSRX_B_CONTINUOUS_RECEIVE_ENABLE]) |=> !s_r.overrun_error_flag)
    else $error("continuous clear kept overrun");
  a_serial_port_enable_clears: assert property (@(posedge sys_clk) disable iff (srst) // RULE17
    (bus.wr && bus.addr == `SSRX_ADDR_CTRL && !bus.wdata[`SSRX_B_SERIAL_PORT_ENABLE]) |=> s_r.qcnt == 2'h0 && !s_r.overrun_error_flag)
    else $error("port disable did not reset");
  // register reads and events
  a_data_read: assert property (@(posedge sys_clk) disable iff (srst) // RULE9
    rd_data |=> rdata == $past(s_r.q0[7:0]))
    else $error("data read not oldest character");
  a_stat_ninth: assert property (@(posedge sys_clk) disable iff (srst) // RULE18
    (bus.rd && bus.addr == `SSRX_ADDR_STAT) |=> rdata[`SSRX_S_RECEIVED_NINTH_BIT] == $past(s_r.q0[8]))
    else $error("ninth bit status wrong");
  a_stat_flag: assert property (@(posedge sys_clk) disable iff (srst) // RULE10
    (bus.rd && bus.addr == `SSRX_ADDR_STAT) |=> rdata[`SSRX_S_RECEIVE_FLAG] == $past(receive_flag))
    else $error("flag status wrong");
  a_stat_ovr: assert property (@(posedge sys_clk) disable iff (srst) // RULE14
    (bus.rd && bus.addr == `SSRX_ADDR_STAT) |=> rdata[`SSRX_S_OVERRUN_ERROR_FLAG] == $past(s_r.overrun_error_flag))
    else $error("overrun status wrong");
  a_pop_last: assert property (@(posedge sys_clk) disable iff (srst) // RULE10
    (rd_data && s_r.qcnt == 2'h1 && !done) |=> !receive_flag)
    else $error("flag kept after last read");
  a_pop_shifts: assert property (@(posedge sys_clk) disable iff (srst) // RULE23
    (rd_data && s_r.qcnt == 2'h2) |=> s_r.q0 == $past(s_r.q1))
    else $error("next character not moved up");
  a_empty_read: assert property (@(posedge sys_clk) disable iff (srst) // RULE10
    (rd_data && s_r.qcnt == 2'h0 && !done) |=> !receive_flag)
    else $error("flag set by empty read");
  a_irq_follows: assert property (@(posedge sys_clk) disable iff (srst) // RULE21
    (receive_flag && s_r.ctrl[`SSRX_B_RECEIVE_INTERRUPT_ENABLE]) |-> receive_irq)
    else $error("irq missing");
  a_irq_masked: assert property (@(posedge sys_clk) disable iff (srst) // RULE21
    !s_r.ctrl[`SSRX_B_RECEIVE_INTERRUPT_ENABLE] |-> !receive_irq)
    else $error("irq while disabled");
endmodule

// *** tb/ssrx_peer.sv ***
// far-end serial peer model
`timescale 1ns/1ps
module ssrx_peer (
  // shared link wires
  input  wire logic       ck_line,
  // control from the bench
  input  wire logic       load,
  input  wire logic       burst,
  input  wire logic [8:0] word,
  input  wire logic [3:0] nbits,
  // driven pins
  output logic            peer_ck,
  output logic            dt
);
  logic [8:0] cur;
  logic [3:0] idx;
  initial begin
    peer_ck = 1'b0;
    dt      = 1'b0;
    cur     = '0;
    idx     = '0;
  end
  always @(posedge load) begin
    cur = word;
    idx = '0;
  end
  // next bit on leading edge, lsb first
  always @(posedge ck_line) begin
    dt = cur[idx];
    if (idx == 4'(nbits - 4'h1)) begin
      idx = '0;
      cur = cur + 9'h001;
    end else begin
      idx = idx + 4'h1;
    end
  end
  // hold time over: line no longer shows last bit
  always @(negedge ck_line) begin
    if (idx == 4'h0) begin
      #35;
      if (!ck_line) dt = ~dt;
    end
  end
  // one clock per data bit
  always @(posedge burst) begin
    repeat (nbits) begin
      #80 peer_ck = 1'b1;
      #80 peer_ck = 1'b0;
    end
  end
endmodule

// *** tb/testbench.sv ***
// bench for the synchronous serial receiver
`timescale 1ns/1ps
`include "ssrx_defs.svh"
module testbench;
  logic                   sys_clk, srst, load, burst, pck, pdt, rd_d;
  logic                   ck_pin_out, ck_pin_oe, dt_pin_out, dt_pin_oe, receive_flag, receive_irq;
  ssrx_pkg::ssrx_bus_type bus;
  logic [7:0]             rdata;
  logic [8:0]             word, w;
  logic [3:0]             nbits;
  logic [7:0]             exp_q[$];
  int                     n_errors, checks, n_ck;
  wire logic ck_pin_in = ck_pin_oe ? ck_pin_out : pck;
  wire logic dt_pin_in = dt_pin_oe ? dt_pin_out : pdt;
  ssrx_top dut (.sys_clk(sys_clk), .srst(srst), .bus(bus), .rdata(rdata), .ck_pin_in(ck_pin_in),
    .ck_pin_out(ck_pin_out), .ck_pin_oe(ck_pin_oe), .dt_pin_in(dt_pin_in), .dt_pin_out(dt_pin_out),
    .dt_pin_oe(dt_pin_oe), .receive_flag(receive_flag), .receive_irq(receive_irq));
  ssrx_peer peer (.ck_line(ck_pin_in), .load(load), .burst(burst), .word(word), .nbits(nbits),
    .peer_ck(pck), .dt(pdt));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge ck_pin_out) n_ck++;
  task automatic check(string name, logic [8:0] seen, logic [8:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic access(logic r, logic [3:0] a, logic [7:0] d);
    @(posedge sys_clk);
    bus <= '{wr: !r, rd: r, addr: a, wdata: d};
    @(posedge sys_clk);
    bus <= '0;
  endtask
  task automatic rd(logic [3:0] a, logic [7:0] e);
    exp_q.push_back(e);
    access(1'b1, a, 8'h00);
    @(posedge sys_clk);
  endtask
  task automatic start(logic [8:0] v, logic [3:0] n);
    @(posedge sys_clk);
    word  <= v;
    nbits <= n;
    load  <= 1'b1;
    @(posedge sys_clk);
    load  <= 1'b0;
  endtask
  task automatic until_ck(int t);
    for (int i = 0; i < 3000 && n_ck < t; i++) @(posedge sys_clk);
  endtask
  task automatic slave_rx();
    @(posedge sys_clk);
    burst <= 1'b1;
    @(posedge sys_clk);
    burst <= 1'b0;
    repeat (170) @(posedge sys_clk);
  endtask
  // read results one cycle after the strobe
  always @(posedge sys_clk) begin
    rd_d <= bus.rd;
    if (rd_d && exp_q.size() > 0) check("rdata", {1'b0, rdata}, {1'b0, exp_q.pop_front()});
  end
  task automatic conclude();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #400000;
    n_errors++;
    conclude();
  end
  initial begin
    void'($urandom(32'h26b774c3));
    {srst, bus, load, burst, word, nbits, rd_d} = '0;
    srst = 1'b1;
    nbits = 4'h8;
    repeat (8) @(posedge sys_clk);
    srst <= 1'b0;
    rd(`SSRX_ADDR_STAT, 8'h00);
    access(1'b0, `SSRX_ADDR_DIVLO, 8'h03);
    access(1'b0, `SSRX_ADDR_CTRL, 8'h8E);
    w = 9'($urandom);
    start(w, 4'h8);
    access(1'b0, `SSRX_ADDR_CTRL, 8'hAE);
    until_ck(8);
    repeat (60) @(posedge sys_clk);
    check("clocks", 9'(n_ck), 9'h008);
    check("dt_oe", {ck_pin_oe, dt_pin_oe}, 9'h002);
    check("irq", {receive_flag, receive_irq}, 9'h003);
    rd(`SSRX_ADDR_STAT, 8'h04);
    rd(`SSRX_ADDR_DATA, w[7:0]);
    check("flag", receive_flag, 9'h000);
    access(1'b0, `SSRX_ADDR_CTRL, 8'hCE);
    start(w, 4'h9);
    for (int k = 1; k <= 3; k++) begin
      access(1'b0, `SSRX_ADDR_CTRL, 8'hEE);
      until_ck(8 + 9 * k);
      repeat (60) @(posedge sys_clk);
    end
    rd(`SSRX_ADDR_STAT, {6'h01, 1'b1, w[8]});
    rd(`SSRX_ADDR_DATA, w[7:0]);
    w = w + 9'h001;
    rd(`SSRX_ADDR_STAT, {6'h01, 1'b0, w[8]});
    rd(`SSRX_ADDR_DATA, w[7:0]);
    access(1'b0, `SSRX_ADDR_CTRL, 8'h8E);
    w = 9'($urandom);
    start(w, 4'h8);
    access(1'b0, `SSRX_ADDR_CTRL, 8'hBE);
    until_ck(52);
    rd(`SSRX_ADDR_CTRL, 8'h9E);
    access(1'b0, `SSRX_ADDR_CTRL, 8'h8E);
    repeat (100) @(posedge sys_clk);
    check("stop", {ck_pin_out, 8'(n_ck)}, 9'd52);
    rd(`SSRX_ADDR_DATA, w[7:0]);
    w = w + 9'h001;
    rd(`SSRX_ADDR_DATA, w[7:0]);
    check("partial", receive_flag, 9'h000);
    access(1'b0, `SSRX_ADDR_CTRL, 8'h84);
    access(1'b0, `SSRX_ADDR_CTRL, 8'h94);
    check("ck_oe", ck_pin_oe, 9'h000);
    w = 9'($urandom);
    start(w, 4'h8);
    repeat (3) slave_rx();
    rd(`SSRX_ADDR_STAT, 8'h06);
    access(1'b0, `SSRX_ADDR_CTRL, 8'h84);
    rd(`SSRX_ADDR_STAT, 8'h04);
    rd(`SSRX_ADDR_DATA, w[7:0]);
    w = w + 9'h001;
    rd(`SSRX_ADDR_DATA, w[7:0]);
    conclude();
  end
endmodule
